// >>> design/rps_remote_port.sv
// rps_remote_port: remote link selector with serial port and flow control
// assumes APB master on core clock; serial pins synchronous to core clock
// por_n_in is the power-on reset, rst_n_in the instrument reset
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
module rps_remote_port #(
	parameter logic [12:0] DIV_2400_P = rps_pkg::DIV_2400
) (
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        por_n_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic             gpib_active_out,
	output logic             serial_active_out,
	output logic      [4:0]  gpib_addr_out,
	output logic             srq_out,
	output logic             txd_out,
	input  wire logic        rxd_in,
	input  wire logic        dsr_in,
	input  wire logic        cts_in,
	output logic             dtr_out,
	output logic             rts_out
);

	typedef enum logic {TX_IDLE, TX_SHIFT} rps_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rps_rx_st_t;

	////////////////////////////////////////////////////////////////////////
	// state
	logic                     wait_reg;
	logic [31:0]              prdata_reg;
	logic                     iface_reg;
	logic                     scpi_reg;
	logic                     srq_pon_reg;
	logic [4:0]               addr_reg;
	rps_pkg::rps_ser_cfg_t    req_cfg_reg;
	rps_pkg::rps_ser_cfg_t    act_cfg_reg;
	logic                     pon_arm_reg;
	logic                     srq_pend_reg;
	logic                     addr_rej_reg;
	logic                     cfg_rej_reg;
	logic                     par_err_reg;
	logic                     frm_err_reg;
	logic                     ovr_reg;
	logic                     paused_reg;
	logic                     tx_full_reg;
	logic [7:0]               tx_hold_reg;
	rps_tx_st_t               tx_st_reg;
	logic [12:0]              tx_cnt_reg;
	logic [3:0]               tx_bit_reg;
	logic [9:0]               tx_frame_reg;
	rps_rx_st_t               rx_st_reg;
	logic [12:0]              rx_cnt_reg;
	logic [2:0]               rx_bit_reg;
	logic [7:0]               rx_sh_reg;
	logic                     rx_done_reg;
	logic [7:0]               rx_char_reg;
	logic                     rx_bad_par_reg;
	logic [rps_pkg::RX_AW-1:0] wr_ptr_reg;
	logic [rps_pkg::RX_AW-1:0] rd_ptr_reg;
	logic [7:0]               count_reg;
	logic [7:0]               count_next;
	logic [7:0]               mem_rdata;
	logic [12:0]              div_sel;
	logic [31:0]              read_val;

	////////////////////////////////////////////////////////////////////////
	// bus decode
	wire acc      = psel_in & penable_in & wait_reg;
	wire wr       = acc & pwrite_in;
	wire rd       = acc & ~pwrite_in;
	wire sel_ctrl = (paddr_in == rps_pkg::OFS_CTRL);
	wire sel_addr = (paddr_in == rps_pkg::OFS_ADDR);
	wire sel_st   = (paddr_in == rps_pkg::OFS_STATUS);
	wire sel_tx   = (paddr_in == rps_pkg::OFS_TXDATA);
	wire sel_rx   = (paddr_in == rps_pkg::OFS_RXDATA);
	wire hit      = sel_ctrl | sel_addr | sel_st | sel_tx | sel_rx;
	wire wr_ctrl  = wr & sel_ctrl;
	wire wr_addr  = wr & sel_addr;
	wire wr_st    = wr & sel_st;
	wire wr_tx    = wr & sel_tx;
	wire rd_rx    = rd & sel_rx;

	assign pready_out  = wait_reg;
	assign pslverr_out = wait_reg & ~hit;
	assign prdata_out  = prdata_reg;

	////////////////////////////////////////////////////////////////////////
	// control write fields
	wire       scpi_new  = pwdata_in[rps_pkg::CTRL_SCPI_BIT];
	wire       mode_chg  = scpi_new != scpi_reg;
	wire [2:0] baud_new  = pwdata_in[rps_pkg::CTRL_BAUD_LSB +: 3];
	wire [1:0] fmt_new   = pwdata_in[rps_pkg::CTRL_FMT_LSB +: 2];
	wire [1:0] flow_new  = pwdata_in[rps_pkg::CTRL_FLOW_LSB +: 2];
	wire       baud_ok   = baud_new <= rps_pkg::BAUD_MAX;
	wire       fmt_ok    = fmt_new != rps_pkg::FMT_BAD;
	wire       ser_ok    = scpi_reg & ~mode_chg;
	wire       cfg_bad   = wr_ctrl & ser_ok & ~(baud_ok & fmt_ok);
	wire [4:0] addr_new  = pwdata_in[4:0];
	wire       addr_ok   = (pwdata_in[31:5] == 27'h0000000) & (addr_new <= rps_pkg::ADDR_MAX);
	wire [5:0] w1c       = wr_st ? pwdata_in[rps_pkg::ST_W1C_MSB:rps_pkg::ST_W1C_LSB] : 6'h00;

	////////////////////////////////////////////////////////////////////////
	// link selection and serial enable
	// one link only
	assign gpib_active_out   = ~iface_reg;
	assign serial_active_out = iface_reg;
	assign gpib_addr_out     = addr_reg;
	assign srq_out           = srq_pend_reg;
	wire ser_en = iface_reg & scpi_reg;

	////////////////////////////////////////////////////////////////////////
	// bit period of the active rate
	always_comb begin
		case (act_cfg_reg.baud)
			3'h0:    div_sel = DIV_2400_P;
			3'h1:    div_sel = rps_pkg::DIV_4800;
			3'h2:    div_sel = rps_pkg::DIV_9600;
			3'h3:    div_sel = rps_pkg::DIV_19200;
			3'h4:    div_sel = rps_pkg::DIV_38400;
			3'h5:    div_sel = rps_pkg::DIV_57600;
			default: div_sel = rps_pkg::DIV_9600;
		endcase
	end

	wire [12:0] div_m1  = div_sel - 13'h0001;
	wire [12:0] half_m1 = {1'b0, div_sel[12:1]} - 13'h0001;

	////////////////////////////////////////////////////////////////////////
	// transmit gating
	// xoff pauses output
	wire flow_xon = act_cfg_reg.flow == rps_pkg::FLOW_XON;
	wire flow_ok  = (act_cfg_reg.flow == rps_pkg::FLOW_NONE) |
	                (flow_xon & ~paused_reg) |
	                ((act_cfg_reg.flow == rps_pkg::FLOW_DSR) & dsr_in) |
	                ((act_cfg_reg.flow == rps_pkg::FLOW_CTS) & cts_in);
	wire tx_start = ser_en & tx_full_reg & (tx_st_reg == TX_IDLE) & flow_ok;
	wire rx_start = ser_en & (rx_st_reg == RX_IDLE) & ~rxd_in;
	wire cfg_load = (tx_st_reg == TX_IDLE) & ~tx_start & (rx_st_reg == RX_IDLE) & ~rx_start;

	// parity bit of the seven data bits
	wire tx_par   = (act_cfg_reg.fmt == rps_pkg::FMT_O7) ? ~^tx_hold_reg[6:0] : ^tx_hold_reg[6:0];
	wire tx_b7    = (act_cfg_reg.fmt == rps_pkg::FMT_N8) ? tx_hold_reg[7] : tx_par;

	////////////////////////////////////////////////////////////////////////
	// receive buffer control
	wire is_pace  = flow_xon & ((rx_char_reg == rps_pkg::CHAR_XOFF) |
	                            (rx_char_reg == rps_pkg::CHAR_XON));
	wire full     = count_reg == 8'(rps_pkg::RX_DEPTH);
	wire empty    = count_reg == 8'h00;
	wire push     = rx_done_reg & ~is_pace & ~full;
	wire pop      = rd_rx & ~empty;
	wire ovr_set  = rx_done_reg & ~is_pace & full;
	wire near_full = count_reg >= rps_pkg::RX_NEAR_FULL;

	always_comb begin
		count_next = count_reg;
		if (push & ~pop) begin
			count_next = count_reg + 8'h01;
		end else if (pop & ~push) begin
			count_next = count_reg - 8'h01;
		end
	end

	assign dtr_out = ~((act_cfg_reg.flow == rps_pkg::FLOW_DSR) & near_full);
	assign rts_out = ~((act_cfg_reg.flow == rps_pkg::FLOW_CTS) & near_full);
	assign txd_out = tx_frame_reg[0];

	////////////////////////////////////////////////////////////////////////
	// read mux
	always_comb begin
		read_val = 32'h00000000;
		case (1'b1)
			sel_ctrl: read_val = {22'h000000, srq_pon_reg, req_cfg_reg.flow,
			                      req_cfg_reg.fmt, req_cfg_reg.baud, scpi_reg, iface_reg};
			sel_addr: read_val = {27'h0000000, addr_reg};
			sel_st:   read_val = {8'h00, count_reg, 5'h00, (req_cfg_reg != act_cfg_reg),
			                      srq_pend_reg, ovr_reg, frm_err_reg, par_err_reg, cfg_rej_reg,
			                      addr_rej_reg, paused_reg, ~empty,
			                      (tx_st_reg == TX_SHIFT), tx_full_reg};
			sel_rx:   read_val = empty ? 32'h00000000 : {24'h000000, mem_rdata};
			default:  read_val = 32'h00000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// bus wait state and read data capture
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			wait_reg   <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			wait_reg <= psel_in & penable_in & ~wait_reg;
			if (psel_in & penable_in & ~wait_reg) begin
				prdata_reg <= read_val;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stored settings kept over instrument reset
	always_ff @(posedge core_clk_in) begin
		if (!por_n_in) begin
			addr_reg    <= rps_pkg::ADDR_RST;
			srq_pon_reg <= rps_pkg::SRQ_PON_RST;
			pon_arm_reg <= 1'b1;
		end else begin
			if (wr_addr & addr_ok) begin
				addr_reg <= addr_new;
			end
			if (wr_ctrl) begin
				srq_pon_reg <= pwdata_in[rps_pkg::CTRL_SRQ_BIT];
			end
			if (rst_n_in) begin
				pon_arm_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!por_n_in) begin
			srq_pend_reg <= 1'b0;
		end else begin
			srq_pend_reg <= (pon_arm_reg & rst_n_in & srq_pon_reg) | (srq_pend_reg & ~w1c[5]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode and serial settings
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			iface_reg   <= 1'b0;
			scpi_reg    <= rps_pkg::SCPI_RST;
			req_cfg_reg <= rps_pkg::CFG_RST;
			act_cfg_reg <= rps_pkg::CFG_RST;
		end else begin
			if (wr_ctrl) begin
				scpi_reg <= scpi_new;
				iface_reg <= ser_ok & pwdata_in[rps_pkg::CTRL_IFACE_BIT];
				if (ser_ok & baud_ok & fmt_ok) begin
					req_cfg_reg <= '{baud: baud_new, fmt: rps_pkg::rps_fmt_t'(fmt_new),
					                 flow: rps_pkg::rps_flow_t'(flow_new)};
				end
			end
			if (cfg_load) begin
				act_cfg_reg <= req_cfg_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky status flags, a set beats a clear
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			addr_rej_reg <= 1'b0;
			cfg_rej_reg  <= 1'b0;
			par_err_reg  <= 1'b0;
			frm_err_reg  <= 1'b0;
			ovr_reg      <= 1'b0;
		end else begin
			addr_rej_reg <= (wr_addr & ~addr_ok) | (addr_rej_reg & ~w1c[0]);
			cfg_rej_reg  <= cfg_bad | (cfg_rej_reg & ~w1c[1]);
			par_err_reg  <= (rx_done_reg & rx_bad_par_reg) | (par_err_reg & ~w1c[2]);
			frm_err_reg  <= (rx_st_reg == RX_STOP & rx_cnt_reg == 13'h0000 & ~rxd_in) |
			                (frm_err_reg & ~w1c[3]);
			ovr_reg      <= ovr_set | (ovr_reg & ~w1c[4]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// in-band pacing
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			paused_reg <= 1'b0;
		end else if (!flow_xon) begin
			paused_reg <= 1'b0;
		end else if (rx_done_reg) begin
			if (rx_char_reg == rps_pkg::CHAR_XOFF) begin
				paused_reg <= 1'b1;
			end else if (rx_char_reg == rps_pkg::CHAR_XON) begin
				paused_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit holding register
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			tx_full_reg <= 1'b0;
			tx_hold_reg <= 8'h00;
		end else if (wr_tx & ~tx_full_reg) begin
			tx_full_reg <= 1'b1;
			tx_hold_reg <= pwdata_in[7:0];
		end else if (tx_start) begin
			tx_full_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit shifter: start, eight bits, stop
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			tx_st_reg    <= TX_IDLE;
			tx_cnt_reg   <= 13'h0000;
			tx_bit_reg   <= 4'h0;
			tx_frame_reg <= 10'h3FF;
		end else begin
			case (tx_st_reg)
				TX_IDLE: begin
					if (tx_start) begin
						tx_st_reg    <= TX_SHIFT;
						tx_cnt_reg   <= div_m1;
						tx_bit_reg   <= 4'h0;
						tx_frame_reg <= {1'b1, tx_b7, tx_hold_reg[6:0], 1'b0};
					end
				end
				TX_SHIFT: begin
					if (tx_cnt_reg != 13'h0000) begin
						tx_cnt_reg <= tx_cnt_reg - 13'h0001;
					end else begin
						tx_frame_reg <= {1'b1, tx_frame_reg[9:1]};
						tx_cnt_reg   <= div_m1;
						tx_bit_reg   <= tx_bit_reg + 4'h1;
						if (tx_bit_reg == rps_pkg::FRAME_LAST) begin
							tx_st_reg <= TX_IDLE;
						end
					end
				end
				default: tx_st_reg <= TX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive shifter, samples at bit centres
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rx_st_reg      <= RX_IDLE;
			rx_cnt_reg     <= 13'h0000;
			rx_bit_reg     <= 3'h0;
			rx_sh_reg      <= 8'h00;
			rx_done_reg    <= 1'b0;
			rx_char_reg    <= 8'h00;
			rx_bad_par_reg <= 1'b0;
		end else begin
			rx_done_reg <= 1'b0;
			case (rx_st_reg)
				RX_IDLE: begin
					if (rx_start) begin
						rx_st_reg  <= RX_START;
						rx_cnt_reg <= half_m1;
					end
				end
				RX_START: begin
					if (rx_cnt_reg != 13'h0000) begin
						rx_cnt_reg <= rx_cnt_reg - 13'h0001;
					end else begin
						rx_st_reg  <= rxd_in ? RX_IDLE : RX_DATA;
						rx_cnt_reg <= div_m1;
						rx_bit_reg <= 3'h0;
					end
				end
				RX_DATA: begin
					if (rx_cnt_reg != 13'h0000) begin
						rx_cnt_reg <= rx_cnt_reg - 13'h0001;
					end else begin
						rx_sh_reg  <= {rxd_in, rx_sh_reg[7:1]};
						rx_cnt_reg <= div_m1;
						rx_bit_reg <= rx_bit_reg + 3'h1;
						if (rx_bit_reg == rps_pkg::DATA_LAST) begin
							rx_st_reg <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_cnt_reg != 13'h0000) begin
						rx_cnt_reg <= rx_cnt_reg - 13'h0001;
					end else begin
						rx_st_reg   <= RX_IDLE;
						rx_done_reg <= 1'b1;
						rx_char_reg <= (act_cfg_reg.fmt == rps_pkg::FMT_N8) ? rx_sh_reg :
						               {1'b0, rx_sh_reg[6:0]};
						rx_bad_par_reg <= (act_cfg_reg.fmt == rps_pkg::FMT_E7) ? ^rx_sh_reg :
						                  (act_cfg_reg.fmt == rps_pkg::FMT_O7) ? ~^rx_sh_reg :
						                  1'b0;
					end
				end
				default: rx_st_reg <= RX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive buffer pointers
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= 8'h00;
		end else begin
			count_reg <= count_next;
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 7'h01;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 7'h01;
			end
		end
	end

	rps_rx_mem u_rx_mem (
		.core_clk_in (core_clk_in),
		.wr_en_in    (push),
		.wr_addr_in  (wr_ptr_reg),
		.wr_data_in  (rx_char_reg),
		.rd_addr_in  (rd_ptr_reg),
		.rd_data_out (mem_rdata)
	);

endmodule // rps_remote_port

// >>> design/rps_pkg.sv
// rps_pkg: constants, reset values and types of the remote port selector
// assumes a 10 MHz core clock and a 32-bit APB register bus
// How it works
// - exactly one remote link active: instrument bus or serial port, never both.
// - after defaults the instrument bus is active with bus address nine.
// - bus address writes of 0 to 30 taken, larger values rejected.
// - bus address survives instrument reset; only power-on reset restores it.
// - any change of command-language mode forces the instrument bus active.
// - serial port configured and selected only while SCPI mode is in effect.
// - power-up service request raised only when its stored enable is set.
// - bit rates 2400 to 57600 baud offered, 9600 after reset.
// - formats 8 bits no parity, 7 even, 7 odd; default 8 none.
// - flow modes none, XON/XOFF, DTR/DSR, RTS/CTS; none after reset.
// - in XON/XOFF mode 0x13 stops transmit, 0x11 resumes it.
// - in DTR/DSR mode characters start only while DSR is true.
// - in DTR/DSR mode DTR goes false at 100 buffered characters.
// - in RTS/CTS mode characters start only while CTS is true.
// - in RTS/CTS mode RTS goes false at 100 buffered characters.
package rps_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_ADDR   = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_TXDATA = 8'h0C;
	localparam logic [7:0] OFS_RXDATA = 8'h10;

	////////////////////////////////////////////////////////////////////////
	// field positions and status layout
	localparam int CTRL_IFACE_BIT = 0;
	localparam int CTRL_SCPI_BIT  = 1;
	localparam int CTRL_BAUD_LSB  = 2;
	localparam int CTRL_FMT_LSB   = 5;
	localparam int CTRL_FLOW_LSB  = 7;
	localparam int CTRL_SRQ_BIT   = 9;
	localparam int ST_W1C_LSB     = 4;
	localparam int ST_W1C_MSB     = 9;
	localparam int ST_CNT_LSB     = 16;

	////////////////////////////////////////////////////////////////////////
	// reset values and limits
	localparam logic [4:0] ADDR_RST    = 5'h09;
	localparam logic [4:0] ADDR_MAX    = 5'h1E;
	localparam logic [2:0] BAUD_RST    = 3'h2;
	localparam logic [2:0] BAUD_MAX    = 3'h5;
	localparam logic       SCPI_RST    = 1'h1;
	localparam logic       SRQ_PON_RST = 1'h1;

	////////////////////////////////////////////////////////////////////////
	// serial characters and buffer
	localparam logic [7:0] CHAR_XOFF   = 8'h13;
	localparam logic [7:0] CHAR_XON    = 8'h11;
	localparam int         RX_DEPTH    = 128;
	localparam int         RX_AW       = 7;
	localparam logic [7:0] RX_NEAR_FULL = 8'h64;
	localparam logic [3:0] FRAME_LAST  = 4'h9;
	localparam logic [2:0] DATA_LAST   = 3'h7;

	////////////////////////////////////////////////////////////////////////
	// bit timing: cycles per bit, nearest whole cycle
	localparam int CLK_HZ = 10_000_000;
	localparam logic [12:0] DIV_2400  = 13'((CLK_HZ + 1200) / 2400);
	localparam logic [12:0] DIV_4800  = 13'((CLK_HZ + 2400) / 4800);
	localparam logic [12:0] DIV_9600  = 13'((CLK_HZ + 4800) / 9600);
	localparam logic [12:0] DIV_19200 = 13'((CLK_HZ + 9600) / 19200);
	localparam logic [12:0] DIV_38400 = 13'((CLK_HZ + 19200) / 38400);
	localparam logic [12:0] DIV_57600 = 13'((CLK_HZ + 28800) / 57600);

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {FMT_N8, FMT_E7, FMT_O7, FMT_BAD} rps_fmt_t;
	typedef enum logic [1:0] {FLOW_NONE, FLOW_XON, FLOW_DSR, FLOW_CTS} rps_flow_t;

	typedef struct packed {
		logic [2:0] baud;
		rps_fmt_t   fmt;
		rps_flow_t  flow;
	} rps_ser_cfg_t;

	localparam rps_ser_cfg_t CFG_RST = '{baud: BAUD_RST, fmt: FMT_N8, flow: FLOW_NONE};

endpackage

// >>> design/rps_rx_mem.sv
// rps_rx_mem: receive character store, one write port, registered read
// assumes the caller keeps its own pointers and never overfills it
`timescale 1ns/1ps
module rps_rx_mem (
	input  wire logic                       core_clk_in,
	input  wire logic                       wr_en_in,
	input  wire logic [rps_pkg::RX_AW-1:0]  wr_addr_in,
	input  wire logic [7:0]                 wr_data_in,
	input  wire logic [rps_pkg::RX_AW-1:0]  rd_addr_in,
	output logic      [7:0]                 rd_data_out
);

	logic [7:0] mem_reg [rps_pkg::RX_DEPTH];

	// write port and registered read
	always_ff @(posedge core_clk_in) begin
		if (wr_en_in) begin
			mem_reg[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem_reg[rd_addr_in];
	end

endmodule // rps_rx_mem

// >>> verif/rps_remote_port_monitor.sv
// rps_remote_port_monitor: port-level checks of the remote port selector
// assumes it is bound onto rps_remote_port, one core clock domain
`timescale 1ns/1ps
module rps_remote_port_monitor (
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        por_n_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic        pready_out,
	input  wire logic        gpib_active_out,
	input  wire logic        serial_active_out,
	input  wire logic [4:0]  gpib_addr_out,
	input  wire logic        srq_out,
	input  wire logic        txd_out,
	input  wire logic        dtr_out,
	input  wire logic        rts_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	// completed control register write
	wire ctrl_wr = psel_in && penable_in && pready_out && pwrite_in
		&& paddr_in == rps_pkg::OFS_CTRL;

	////////////////////////////////////////////////////////////////////////
	chk_one_link: assert property (gpib_active_out != serial_active_out)
		else $error("link selects not exclusive");
	chk_reset_bus: assert property (!$past(rst_n_in) |-> gpib_active_out && txd_out)
		else $error("bus link or idle line missing after reset");
	chk_addr_range: assert property (gpib_addr_out <= rps_pkg::ADDR_MAX)
		else $error("bus address above range");
	chk_addr_keep: assert property (disable iff (!por_n_in)
		!rst_n_in |=> $stable(gpib_addr_out)) else $error("address lost on reset");
	chk_mode_bus: assert property (ctrl_wr && !pwdata_in[0] |=> gpib_active_out)
		else $error("bus link not selected");
	chk_tx_serial: assert property ($fell(txd_out) |-> serial_active_out)
		else $error("character sent without serial link");
	chk_srq_pon: assert property (disable iff (!por_n_in)
		$rose(por_n_in) && rst_n_in |=> srq_out) else $error("no power-up request");
	chk_flow_lines: assert property (dtr_out || rts_out)
		else $error("both pacing lines false");

	// main scenarios
	cov_ctrl: cover property (ctrl_wr);
	cov_tx: cover property ($fell(txd_out));
	cov_rts: cover property ($fell(rts_out));
endmodule // rps_remote_port_monitor

bind rps_remote_port rps_remote_port_monitor i_mon (.core_clk_in, .rst_n_in, .por_n_in,
	.paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in, .pready_out, .gpib_active_out,
	.serial_active_out, .gpib_addr_out, .srq_out, .txd_out, .dtr_out, .rts_out);

// >>> verif/rps_host_model.sv
// rps_host_model: host end of the serial line with pacing lines
// assumes one bit lasts DIV core cycles; line idles high
`timescale 1ns/1ps
module rps_host_model #(
	parameter int DIV = 16
) (
	input  wire logic core_clk_in,
	input  wire logic txd_in,
	output logic      rxd_out,
	output logic      dsr_out,
	output logic      cts_out
);
	initial begin
		rxd_out = 1'h1;
		dsr_out = 1'h1;
		cts_out = 1'h1;
	end

	// one whole frame, lsb first, host paces itself
	task automatic send(input logic [7:0] c);
		logic [9:0] f;
		f = {1'h1, c, 1'h0};
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk_in);
			rxd_out <= f[i];
			repeat (DIV - 1) @(posedge core_clk_in);
		end
	endtask

	task automatic set_ready(input logic v);
		@(posedge core_clk_in);
		dsr_out <= v;
		cts_out <= v;
	endtask

	// capture one character, or report none within 400 cycles
	task automatic recv(output logic [7:0] c, output logic seen);
		c = 8'h00;
		seen = 1'h0;
		for (int n = 0; n < 400 && !seen; n++) begin
			@(posedge core_clk_in);
			seen = !txd_in;
		end
		if (seen) begin
			repeat (DIV / 2) @(posedge core_clk_in);
			for (int i = 0; i < 8; i++) begin
				repeat (DIV) @(posedge core_clk_in);
				c[i] = txd_in;
			end
			repeat (DIV) @(posedge core_clk_in);
		end
	endtask
endmodule // rps_host_model

// >>> verif/testbench.sv
// testbench: directed scenarios of the remote port selector
// assumes 2400 baud uses DIV core cycles per bit
`timescale 1ns/1ps
module testbench;
	localparam int DIV = 16;
	logic        core_clk_in, rst_n_in, por_n_in, psel_in, penable_in, pwrite_in;
	logic [7:0]  paddr_in, ch;
	logic [31:0] pwdata_in, prdata_out, rd_val;
	logic        pready_out, pslverr_out, gpib_active_out, serial_active_out, srq_out;
	logic [4:0]  gpib_addr_out;
	logic        txd_out, rxd_in, dsr_in, cts_in, dtr_out, rts_out, last_err, seen;
	int          errors, checks_done;

	rps_remote_port #(.DIV_2400_P(13'(DIV))) i_dut (.core_clk_in, .rst_n_in, .por_n_in,
		.paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in, .prdata_out, .pready_out,
		.pslverr_out, .gpib_active_out, .serial_active_out, .gpib_addr_out, .srq_out,
		.txd_out, .rxd_in, .dsr_in, .cts_in, .dtr_out, .rts_out);
	rps_host_model #(.DIV(DIV)) i_host (.core_clk_in, .txd_in(txd_out), .rxd_out(rxd_in),
		.dsr_out(dsr_in), .cts_out(cts_in));

	initial begin
		core_clk_in = 1'h0;
		forever #50 core_clk_in = ~core_clk_in;
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	// one transfer: setup, access until ready, then release
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		psel_in <= 1'h1;
		penable_in <= 1'h0;
		paddr_in <= a;
		pwrite_in <= w;
		pwdata_in <= d;
		@(posedge core_clk_in);
		penable_in <= 1'h1;
		do @(posedge core_clk_in); while (pready_out !== 1'h1);
		rd_val = prdata_out;
		last_err = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
		@(negedge core_clk_in);
	endtask

	task automatic complete_run;
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic t_defaults;
		apb(1'h0, rps_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", rd_val, 32'h20A); // defaults
		chk("link", gpib_active_out, 1'h1); // bus
		chk("addr", gpib_addr_out, 5'h09); // nine
		chk("srq", srq_out, 1'h1); // request
	endtask

	task automatic t_addr;
		apb(1'h1, rps_pkg::OFS_ADDR, 32'h1E);
		apb(1'h1, rps_pkg::OFS_ADDR, 32'h1F);
		chk("addr", gpib_addr_out, 5'h1E); // top kept
		apb(1'h0, rps_pkg::OFS_STATUS, 32'h0);
		chk("rej", rd_val[4], 1'h1); // flagged
		apb(1'h0, 8'h14, 32'h0);
		chk("unmapped", last_err, 1'h1); // refused
		@(posedge core_clk_in);
		rst_n_in <= 1'h0;
		repeat (2) @(posedge core_clk_in);
		rst_n_in <= 1'h1;
		@(negedge core_clk_in);
		chk("kept", gpib_addr_out, 5'h1E); // after reset
	endtask

	task automatic t_serial;
		apb(1'h1, rps_pkg::OFS_CTRL, 32'h203);
		chk("links", {gpib_active_out, serial_active_out}, 2'h1); // serial
		apb(1'h1, rps_pkg::OFS_TXDATA, 32'h5A);
		i_host.recv(ch, seen);
		chk("tx", ch, 8'h5A); // frame
		i_host.send(8'hC3);
		apb(1'h0, rps_pkg::OFS_RXDATA, 32'h0);
		chk("rx", rd_val, 32'hC3); // frame
		apb(1'h1, rps_pkg::OFS_CTRL, 32'h223);
		i_host.send(8'hC3);
		apb(1'h0, rps_pkg::OFS_RXDATA, 32'h0);
		chk("rx 7e", rd_val, 32'h43); // parity stripped
	endtask

	task automatic t_xon;
		apb(1'h1, rps_pkg::OFS_CTRL, 32'h283);
		i_host.send(rps_pkg::CHAR_XOFF);
		apb(1'h1, rps_pkg::OFS_TXDATA, 32'h3C);
		i_host.recv(ch, seen);
		chk("paused", seen, 1'h0); // stop
		fork
			i_host.send(rps_pkg::CHAR_XON);
			i_host.recv(ch, seen);
		join
		chk("resumed", ch, 8'h3C); // resume
		apb(1'h0, rps_pkg::OFS_STATUS, 32'h0);
		chk("consumed", rd_val[23:16], 8'h00); // not stored
	endtask

	task automatic t_cts;
		i_host.set_ready(1'h0);
		apb(1'h1, rps_pkg::OFS_CTRL, 32'h383);
		apb(1'h1, rps_pkg::OFS_TXDATA, 32'hA5);
		i_host.recv(ch, seen);
		chk("held", seen, 1'h0); // gated
		i_host.set_ready(1'h1);
		i_host.recv(ch, seen);
		chk("sent", ch, 8'hA5); // released
		for (int i = 0; i < 100; i++) begin
			chk("rts", rts_out, 1'h1); // room left
			i_host.send(8'(i + 1));
		end
		@(negedge core_clk_in);
		chk("rts full", {dtr_out, rts_out}, 2'h2); // near full
		apb(1'h0, rps_pkg::OFS_RXDATA, 32'h0);
		chk("first", rd_val, 32'h1); // oldest kept
		chk("rts free", rts_out, 1'h1); // space again
		apb(1'h1, rps_pkg::OFS_CTRL, 32'h303);
		i_host.send(8'h77);
		i_host.set_ready(1'h0);
		apb(1'h1, rps_pkg::OFS_TXDATA, 32'h96);
		i_host.recv(ch, seen);
		chk("dsr held", seen, 1'h0); // gated
		chk("dtr full", {dtr_out, rts_out}, 2'h1); // near full
		i_host.set_ready(1'h1);
		i_host.recv(ch, seen);
		chk("dsr sent", ch, 8'h96); // released
	endtask

	task automatic t_mode;
		apb(1'h1, rps_pkg::OFS_CTRL, 32'h201);
		chk("mode", gpib_active_out, 1'h1); // bus
		apb(1'h1, rps_pkg::OFS_CTRL, 32'h201);
		chk("no serial", gpib_active_out, 1'h1); // bus only
	endtask

	initial begin
		{rst_n_in, por_n_in, psel_in, penable_in, pwrite_in} = 5'h00;
		paddr_in = 8'h00;
		pwdata_in = 32'h0;
		errors = 0;
		checks_done = 0;
		repeat (12) @(posedge core_clk_in);
		rst_n_in <= 1'h1;
		por_n_in <= 1'h1;
		t_defaults;
		t_addr;
		t_serial;
		t_xon;
		t_cts;
		t_mode;
		complete_run;
	end

	// hang guard
	initial begin
		#(100 * 60000);
		errors++;
		complete_run;
	end
endmodule // testbench
